//--- rtl/bccc_top.sv
`include "bccc_regs.svh"
`default_nettype none
module bccc_top (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic clk_en_i,
    input wire logic cell_mode_strap_pin_i,
    input wire logic osc_clk_i,
    input wire logic sleep_i,
    input wire logic regulated_i,
    input wire logic [`BCCC_DUTY_W-1:0] duty_demand_i,
    input wire bccc_pkg::bccc_cfg_t cfg_i,
    input wire logic cfg_we_i,
    output logic one_cell_o,
    output logic conv_clk_o,
    output logic switch_on_o,
    output logic converter_enable_o,
    output logic bypass_closed_o,
    output logic switch_size_select_o,
    output logic peak_current_limit_select_o
);
    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [1:0] strap_sync_reg;
    logic [1:0] osc_sync_reg;
    logic [1:0] por_sync_reg;
    // strap and power-on paths ignore rst_i so that a power-on reset
    // overlapping rst_i still latches the cell mode
    always_ff @(posedge sys_clk_i)
    begin
        if (clk_en_i)
        begin
            strap_sync_reg <= {strap_sync_reg[0], cell_mode_strap_pin_i};
            por_sync_reg <= {por_sync_reg[0], por_i};
        end
    end
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            osc_sync_reg <= 2'h0;
        else if (clk_en_i)
            osc_sync_reg <= {osc_sync_reg[0], osc_clk_i};
    end

    // ------------------------------------------------------------
    // cell mode latch, only power-on reset writes it
    // ------------------------------------------------------------
    bccc_pkg::bccc_cell_t cell_reg;
    always_ff @(posedge sys_clk_i)
    begin
        if (clk_en_i && por_sync_reg[1])
            cell_reg <= strap_sync_reg[1] ? bccc_pkg::BCCC_CELL_ONE
                                          : bccc_pkg::BCCC_CELL_TWO;
    end
    logic one_cell;
    assign one_cell = (cell_reg == bccc_pkg::BCCC_CELL_ONE);

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    bccc_pkg::bccc_cfg_t cfg_reg;
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cfg_reg <= '0;
            cfg_reg.converter_clock_divider <= `BCCC_DIV_RST;
            cfg_reg.switch_size_select <= `BCCC_SWITCH_SIZE_SELECT_RST;
            cfg_reg.peak_current_limit_select <= `BCCC_ILIM_RST;
        end
        else if (clk_en_i && cfg_we_i)
            cfg_reg <= cfg_i;
    end

    // ------------------------------------------------------------
    // switching clock: invert, divide, select
    // ------------------------------------------------------------
    logic div_phase_reg;
    logic [2:0] div_cnt_reg;
    logic [2:0] div_mask;
    always_comb
    begin
        case (cfg_reg.converter_clock_divider)
            2'h0: div_mask = 3'h0;
            2'h1: div_mask = 3'h1;
            2'h2: div_mask = 3'h3;
            default: div_mask = 3'h7;
        endcase
    end
    // invert moves the divided edge by half a system period
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            div_cnt_reg <= 3'h0;
        else if (clk_en_i)
            div_cnt_reg <= (div_cnt_reg + 3'h1) & div_mask;
    end
    always_ff @(negedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            div_phase_reg <= 1'b0;
        else if (clk_en_i)
            div_phase_reg <= (div_cnt_reg == 3'h0);
    end
    logic sys_tick;
    assign sys_tick = cfg_reg.converter_clock_invert ? div_phase_reg
                                                     : (div_cnt_reg == 3'h0);
    logic osc_prev_reg;
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            osc_prev_reg <= 1'b0;
        else if (clk_en_i)
            osc_prev_reg <= osc_sync_reg[1];
    end
    logic tick;
    assign tick = cfg_reg.converter_clock_source_select
                  ? (osc_sync_reg[1] & ~osc_prev_reg) : sys_tick;

    // ------------------------------------------------------------
    // power mode sequencing
    // ------------------------------------------------------------
    logic run_req;
    assign run_req = one_cell && !sleep_i;
    logic [1:0] gap_reg;
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            converter_enable_o <= 1'b0;
            bypass_closed_o <= 1'b0;
            gap_reg <= 2'h0;
        end
        else if (clk_en_i)
        begin
            if (!run_req)
            begin
                converter_enable_o <= 1'b0;
                bypass_closed_o <= one_cell && sleep_i
                                   && !cfg_reg.sleep_output_float;
                gap_reg <= `BCCC_BYPASS_GAP;
            end
            else
            begin
                bypass_closed_o <= 1'b0;
                if (gap_reg != 2'h0)
                    gap_reg <= gap_reg - 2'h1;
                else if (!bypass_closed_o)
                    converter_enable_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // duty cycle and pulse skipping
    // ------------------------------------------------------------
    logic [`BCCC_DUTY_W-1:0] phase_reg;
    logic [`BCCC_DUTY_W-1:0] width_reg;
    logic started_reg;
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            started_reg <= 1'b0;
        else if (clk_en_i && regulated_i)
            started_reg <= 1'b1;
    end
    logic [`BCCC_DUTY_W-1:0] demand;
    assign demand = started_reg ? duty_demand_i
                                : {1'b1, {(`BCCC_DUTY_W-1){1'b0}}};
    logic [`BCCC_DUTY_W-1:0] min_w;
    assign min_w = {{(`BCCC_DUTY_W-`BCCC_PW_W){1'b0}}, cfg_reg.min_pulse_width};
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            phase_reg <= '0;
            width_reg <= '0;
            switch_on_o <= 1'b0;
            conv_clk_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (tick)
                conv_clk_o <= ~conv_clk_o;
            if (!converter_enable_o)
            begin
                phase_reg <= '0;
                switch_on_o <= 1'b0;
            end
            else if (tick)
            begin
                phase_reg <= phase_reg + {{(`BCCC_DUTY_W-1){1'b0}}, 1'b1};
                if (phase_reg == '0)
                begin
                    width_reg <= (demand < min_w) ? '0 : demand;
                    switch_on_o <= (demand >= min_w) && (demand != '0);
                end
                else if (phase_reg >= width_reg)
                    switch_on_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            one_cell_o <= 1'b0;
            switch_size_select_o <= `BCCC_SWITCH_SIZE_SELECT_RST;
            peak_current_limit_select_o <= `BCCC_ILIM_RST;
        end
        else if (clk_en_i)
        begin
            one_cell_o <= one_cell;
            switch_size_select_o <= cfg_reg.switch_size_select;
            peak_current_limit_select_o <= cfg_reg.peak_current_limit_select;
        end
    end
endmodule // bccc_top
`default_nettype wire

//--- rtl/bccc_regs.svh
`ifndef BCCC_REGS_SVH
`define BCCC_REGS_SVH
`define BCCC_DIV_W 2
`define BCCC_DIV_RST 2'h0
`define BCCC_PW_W 2
`define BCCC_DUTY_W 4
`define BCCC_ILIM_RST 1'h0
`define BCCC_SWITCH_SIZE_SELECT_RST 1'h1
`define BCCC_BYPASS_GAP 2'h2
`endif

//--- rtl/bccc_pkg.sv
`default_nettype none
package bccc_pkg;
    typedef enum logic [1:0] {
        BCCC_CELL_TWO,
        BCCC_CELL_ONE
    } bccc_cell_t;
    typedef struct packed {
        logic converter_clock_source_select;
        logic [1:0] converter_clock_divider;
        logic converter_clock_invert;
        logic sleep_output_float;
        logic switch_size_select;
        logic peak_current_limit_select;
        logic [1:0] min_pulse_width;
    } bccc_cfg_t;
    typedef struct packed {
        logic converter_enable;
        logic switching;
        logic bypass_closed;
        logic rail_float;
    } bccc_stat_t;
endpackage
`default_nettype wire

//--- verification/bccc_top_assertions.sv
`default_nettype none
module bccc_checker (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic clk_en_i,
    input wire logic cell_mode_strap_pin_i,
    input wire logic sleep_i,
    input wire logic cfg_we_i,
    input wire bccc_pkg::bccc_cfg_t cfg_i,
    input wire logic one_cell_o,
    input wire logic converter_enable_o,
    input wire logic bypass_closed_o,
    input wire logic switch_size_select_o,
    input wire logic peak_current_limit_select_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence wake_s;
        $fell(sleep_i) && clk_en_i && one_cell_o;
    endsequence
    sequence opened_s;
        !bypass_closed_o ##[1:5] converter_enable_o;
    endsequence
    strap_load_a: assert property ((por_i && clk_en_i) ##1 clk_en_i [*3]
        |=> one_cell_o == $past(cell_mode_strap_pin_i, 4))
        else $error("strap");
    two_cell_off_a: assert property (!one_cell_o [*2] |->
        !converter_enable_o) else $error("two-cell enable");
    sleep_off_a: assert property (one_cell_o && sleep_i && clk_en_i
        |=> !converter_enable_o) else $error("sleep enable");
    cell_hold_a: assert property ((!por_i) [*4] |=>
        $stable(one_cell_o)) else $error("cell changed");
    no_overlap_a: assert property (!(bypass_closed_o &&
        converter_enable_o)) else $error("overlap");
    wake_order_a: assert property (wake_s |=> opened_s)
        else $error("wake order");
    limit_reset_a: assert property ($fell(rst_i) |->
        !peak_current_limit_select_o && switch_size_select_o)
        else $error("limit reset");
    cfg_take_a: assert property ((cfg_we_i && clk_en_i) ##1 clk_en_i |=>
        peak_current_limit_select_o ==
        $past(cfg_i.peak_current_limit_select, 2)
        && switch_size_select_o == $past(cfg_i.switch_size_select, 2))
        else $error("cfg take");
    cfg_hold_a: assert property (!cfg_we_i && clk_en_i |-> ##2
        $stable(peak_current_limit_select_o) && $stable(switch_size_select_o))
        else $error("cfg hold");
endmodule // bccc_checker
bind bccc_top bccc_checker chk_u (.*);
`default_nettype wire

//--- verification/bccc_top_bench.sv
`include "bccc_regs.svh"
`default_nettype none
module bccc_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 0, rst_i = 1, por_i = 1, clk_en_i = 1, sleep_i = 0;
    logic cell_mode_strap_pin_i = 1, osc_clk_i = 0, regulated_i = 0;
    logic cfg_we_i = 0, one_cell_o, conv_clk_o, switch_on_o;
    logic converter_enable_o, bypass_closed_o, switch_size_select_o;
    logic peak_current_limit_select_o;
    logic [`BCCC_DUTY_W-1:0] duty_demand_i = '0;
    bccc_pkg::bccc_cfg_t cfg_i = '0;
    int fails = 0, tests_run = 0, hi, tg;
    bccc_top dut_u (.*);
    initial forever #10 sys_clk_i = ~sys_clk_i;
    initial forever #208 osc_clk_i = ~osc_clk_i;
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask
    task automatic flag(input logic g, input logic e);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("Error at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic near(input int g, input int lo, input int up);
        tests_run++;
        if (g < lo || g > up)
        begin
            fails++;
            $display("Error at %0t: got %h exp %h", $time, g, lo);
        end
    endtask
    task automatic wr();
        cfg_we_i = 1;
        tick(1);
        cfg_we_i = 0;
        tick(1);
    endtask
    task automatic pwr(input logic s);
        cell_mode_strap_pin_i = s;
        por_i = 1;
        tick(4);
        por_i = 0;
        tick(4);
    endtask
    task automatic meas(input int n);
        logic p;
        logic bad;
        hi = 0;
        tg = 0;
        bad = 0;
        p = conv_clk_o;
        repeat (n)
        begin
            tick(1);
            if (switch_on_o === 1'b1) hi++;
            if (conv_clk_o !== p) tg++;
            if ($isunknown({switch_on_o, conv_clk_o})) bad = 1;
            p = conv_clk_o;
        end
        // an unknown output must fail every count check
        if (bad)
        begin
            hi = -1;
            tg = -1;
        end
    endtask
    task automatic t_cell();
        flag(switch_size_select_o, 1'b1);
        flag(peak_current_limit_select_o, 1'b0);
        flag(one_cell_o, 1'b1);
        cell_mode_strap_pin_i = 0;
        rst_i = 1;
        tick(2);
        rst_i = 0;
        tick(2);
        flag(one_cell_o, 1'b1);
        pwr(0);
        flag(one_cell_o, 1'b0);
        flag(converter_enable_o, 1'b0);
        pwr(1);
        meas(64);
        near(hi, 31, 33);
        flag(converter_enable_o, 1'b1);
        $display("test cell done");
    endtask
    task automatic t_clk();
        regulated_i = 1;
        for (int d = 0; d < 4; d++)
        begin
            cfg_i.converter_clock_divider = d[1:0];
            cfg_i.converter_clock_invert = d[0];
            wr();
            tick(4);
            meas(64);
            near(tg, (64 >> d) - 1, (64 >> d) + 1);
        end
        cfg_i.converter_clock_source_select = 1;
        wr();
        tick(4);
        meas(64);
        near(tg, 2, 4);
        cfg_i = '0;
        wr();
        $display("test clk done");
    endtask
    task automatic t_skip();
        cfg_i.min_pulse_width = 2'h3;
        wr();
        duty_demand_i = 4'h2;
        tick(4);
        meas(64);
        near(hi, 0, 0);
        duty_demand_i = 4'h5;
        tick(16);
        meas(64);
        near(hi, 19, 21);
        $display("test skip done");
    endtask
    task automatic t_sleep();
        sleep_i = 1;
        tick(3);
        flag(converter_enable_o, 1'b0);
        flag(bypass_closed_o, 1'b1);
        sleep_i = 0;
        tick(8);
        flag(bypass_closed_o, 1'b0);
        flag(converter_enable_o, 1'b1);
        cfg_i.sleep_output_float = 1;
        wr();
        sleep_i = 1;
        tick(3);
        meas(32);
        near(hi, 0, 0);
        flag(bypass_closed_o, 1'b0);
        sleep_i = 0;
        tick(8);
        $display("test sleep done");
    endtask
    task automatic t_cfg();
        for (int k = 0; k < 4; k++)
        begin
            cfg_i.switch_size_select = k[1];
            cfg_i.peak_current_limit_select = k[0];
            wr();
            flag(switch_size_select_o, k[1]);
            flag(peak_current_limit_select_o, k[0]);
        end
        clk_en_i = 0;
        cfg_i.peak_current_limit_select = 0;
        wr();
        clk_en_i = 1;
        flag(peak_current_limit_select_o, 1'b1);
        $display("test cfg done");
    endtask
    task automatic stop_test();
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #100000;
        fails++;
        stop_test();
    end
    initial
    begin
        tick(8);
        rst_i = 0;
        por_i = 0;
        tick(4);
        t_cell();
        t_clk();
        // adc sync is left to software, the block has no port for it
        t_skip();
        t_sleep();
        t_cfg();
        stop_test();
    end
endmodule // bccc_top_bench
`default_nettype wire
